//--- core/sccu_ctrl.sv
// Serial port control register, APB slave, transmit queue and link crossing
//
// How it works
// R1: In framed mode with frame_pulse_edge_sel set the sync pulse shares the first bit clock.
// R2: deep_buffer_enable set gives the deep transmit queue, clear gives single-word buffering.
// R3: The port runs only while the enable bit is one.
// R4: With idle_halt set the port stops while the chip is idle, else it runs on.
// R5: With serial_out_pin_release set the port leaves serial_data_out_pin undriven; the code applies the bit only from the start of the next word sent.
// R6: Audio with both width bits set moves 24-bit data in 32-bit channels of a 64-bit frame.
// R7: Audio with only wide_word_sel set moves 32-bit data in 32-bit channels.
// R8: Audio with both width bits clear moves 16-bit data in 16-bit channels.
// R9: Without audio, wide_word_sel gives 32-bit words and both clear gives 8-bit words.
// R10: In master mode input_sample_phase picks end or middle of the output time for capture.
// R11: In slave mode input_sample_phase is treated as zero.
// R12: A one in input_sample_phase is taken only once master_enable already holds one.
// R13: Phase one samples at the end of the output time, zero at its middle.
// R14: The clock-edge bit picks which clock transition moves output data.
// R15: The clock-edge bit is ignored in framed mode.
// R16: deep_buffer_enable takes writes only while the port is disabled.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sccu_ctrl #(
    parameter int DEEP_DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic sdi,
    input wire logic idle_mode,
    output logic sclk_out,
    output logic sclk_oe,
    output logic sdo,
    output logic sdo_oe,
    output logic frame_sync
);

    localparam int PW = (DEEP_DEPTH > 1) ? $clog2(DEEP_DEPTH) : 1;
    localparam logic [PW:0] DEEP_LIM = (PW + 1)'(DEEP_DEPTH);
    localparam logic [PW:0] STD_LIM = (PW + 1)'(1);

    generate
        if ((DEEP_DEPTH < 2) || (DEEP_DEPTH > 64) || ((1 << PW) != DEEP_DEPTH))
        begin : g_bad_depth
            $error("DEEP_DEPTH must be a power of two from 2 to 64");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [31:0] ctrl;
        logic [DEEP_DEPTH-1:0][31:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic ovf;
        logic req;
        logic [31:0] txw;
        sccu_pkg::sccu_cfg_t cfg;
        logic audio24;
        logic run;
        logic ack1;
        logic ack2;
        logic ackseen;
        logic [31:0] rxd;
        logic rxv;
        logic idle1;
        logic idle2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sccu_ctl_t;

    sccu_ctl_t q;
    sccu_ctl_t d;

    sccu_link_if lk ();

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of the control word into link settings

    function automatic sccu_pkg::sccu_cfg_t cfg_of(input logic [31:0] c);
        sccu_pkg::sccu_cfg_t f;
        f.master = c[sccu_pkg::B_MASTER];
        f.framed = c[sccu_pkg::B_FRAMED];
        // Audio forces the idle-high clock whatever the polarity bit says
        f.pol = c[sccu_pkg::B_AUDIO] | c[sccu_pkg::B_POL];
        f.cke = c[sccu_pkg::B_CKE] & ~c[sccu_pkg::B_FRAMED]; // R15
        f.input_sample_phase = c[sccu_pkg::B_SMP] & c[sccu_pkg::B_MASTER]; // R11
        f.fpe = c[sccu_pkg::B_FPE];
        f.pin_rel = c[sccu_pkg::B_REL];
        if (c[sccu_pkg::B_AUDIO])
        begin
            // Channel width; the 24-bit case is padded to a 32-bit channel
            f.nbits = c[sccu_pkg::B_WIDE] ? sccu_pkg::BITS_32 : sccu_pkg::BITS_16; // R6 R7 R8
        end
        else if (c[sccu_pkg::B_WIDE])
        begin
            f.nbits = sccu_pkg::BITS_32; // R9
        end
        else if (c[sccu_pkg::B_HALF])
        begin
            f.nbits = sccu_pkg::BITS_16;
        end
        else
        begin
            f.nbits = sccu_pkg::BITS_8; // R9
        end
        return f;
    endfunction : cfg_of

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic push;
    logic pop;
    logic busy;
    logic [PW:0] limit;
    logic [31:0] wv;
    logic [31:0] head;
    logic [31:0] stat;

    always_comb
    begin
        d = q;
        setup = psel && !penable && !q.pready;
        access = psel && penable && q.pready;
        wr = access && pwrite;
        rd = access && !pwrite;
        busy = (q.req != q.ackseen);
        limit = q.ctrl[sccu_pkg::B_DEEP] ? DEEP_LIM : STD_LIM; // R2
        push = 1'b0;
        pop = 1'b0;
        head = q.mem[q.rp];
        wv = pwdata & sccu_pkg::CTRL_MASK;

        stat = '0;
        stat[sccu_pkg::S_BUSY] = busy;
        stat[sccu_pkg::S_FULL] = (q.cnt >= limit);
        stat[sccu_pkg::S_EMPTY] = (q.cnt == '0);
        stat[sccu_pkg::S_RXV] = q.rxv;
        stat[sccu_pkg::S_OVF] = q.ovf;
        stat[sccu_pkg::S_CNT +: PW + 1] = q.cnt;

        // Pins from outside the clock domain pass two flops first
        d.idle1 = idle_mode;
        d.idle2 = q.idle1;
        d.ack1 = lk.ack_tgl;
        d.ack2 = q.ack1;

        ////////////////////////////////////////////////////////////////////////////
        // APB: data is fetched in the setup cycle so that prdata leaves a flop;
        // this costs one fixed wait-free access phase and no more
        d.pready = setup;
        d.pslverr = 1'b0;
        d.prdata = '0;
        if (setup)
        begin
            case (paddr)
                sccu_pkg::OFF_CTRL:
                begin
                    d.prdata = q.ctrl;
                end
                sccu_pkg::OFF_STAT:
                begin
                    d.prdata = stat;
                end
                sccu_pkg::OFF_TX:
                begin
                    d.prdata = '0;
                end
                sccu_pkg::OFF_RX:
                begin
                    d.prdata = q.rxd;
                end
                default:
                begin
                    d.pslverr = 1'b1;
                end
            endcase
            // Write answers carry zero data
            if (pwrite)
            begin
                d.prdata = '0;
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // Register writes and read side effects
        if (wr && (paddr == sccu_pkg::OFF_CTRL))
        begin
            if (q.ctrl[sccu_pkg::B_ON])
            begin
                wv[sccu_pkg::B_DEEP] = q.ctrl[sccu_pkg::B_DEEP]; // R16
            end
            wv[sccu_pkg::B_SMP] = pwdata[sccu_pkg::B_SMP] & q.ctrl[sccu_pkg::B_MASTER]; // R12
            d.ctrl = wv;
        end
        if (wr && (paddr == sccu_pkg::OFF_STAT) && pwdata[sccu_pkg::S_OVF])
        begin
            d.ovf = 1'b0;
        end
        if (rd && (paddr == sccu_pkg::OFF_RX))
        begin
            d.rxv = 1'b0;
        end
        if (wr && (paddr == sccu_pkg::OFF_TX))
        begin
            if (q.cnt < limit) // R2
            begin
                push = 1'b1;
                d.mem[q.wp] = pwdata;
                d.wp = q.wp + PW'(1);
            end
            else
            begin
                // A full queue drops the word and flags it
                d.ovf = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // Launch one word at a time; the next waits for the answer toggle
        d.run = q.ctrl[sccu_pkg::B_ON] && !(q.ctrl[sccu_pkg::B_IDLE_HALT] && q.idle2); // R3 R4
        if (q.run && !busy && (q.cnt != '0))
        begin
            pop = 1'b1;
            d.rp = q.rp + PW'(1);
            d.cfg = cfg_of(q.ctrl);
            d.audio24 = q.ctrl[sccu_pkg::B_AUDIO] && q.ctrl[sccu_pkg::B_WIDE]
                && q.ctrl[sccu_pkg::B_HALF];
            if (d.audio24)
            begin
                d.txw = {head[23:0], 8'h00}; // R6
            end
            else
            begin
                d.txw = head;
            end
            d.req = ~q.req;
        end
        d.cnt = q.cnt + (PW + 1)'(push) - (PW + 1)'(pop);

        // Returned word; the set beats a same-cycle read clear
        if (q.ack2 != q.ackseen)
        begin
            d.ackseen = q.ack2;
            d.rxd = q.audio24 ? (lk.rx_word >> sccu_pkg::AUDIO_PAD) : lk.rx_word; // R6
            d.rxv = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossing: word and settings hold still while the toggle is in flight

    assign lk.req_tgl = q.req;
    assign lk.tx_word = q.txw;
    assign lk.cfg = q.cfg;
    assign lk.run = q.run;

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    sccu_engine u_engine (
        .link_clk(link_clk),
        .presetn(presetn),
        .lk(lk.eng),
        .sdi(sdi),
        .sclk_out(sclk_out),
        .sclk_oe(sclk_oe),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .frame_sync(frame_sync)
    );

endmodule : sccu_ctrl
`default_nettype wire

//--- core/sccu_engine.sv
// Link-side shift engine on the link clock
`timescale 1ns/1ps
`default_nettype none
module sccu_engine (
    input wire logic link_clk,
    input wire logic presetn,
    sccu_link_if.eng lk,
    input wire logic sdi,
    output logic sclk_out,
    output logic sclk_oe,
    output logic sdo,
    output logic sdo_oe,
    output logic frame_sync
);

    typedef enum logic [4:0] {
        E_IDLE = 5'b00001,
        E_SYNC = 5'b00010,
        E_SHIFT = 5'b00100,
        E_DONE = 5'b01000,
        E_TAIL = 5'b10000
    } sccu_est_t;

    typedef struct packed {
        sccu_est_t st;
        logic req1;
        logic req2;
        logic seen;
        logic run1;
        logic run2;
        logic sdi1;
        logic sdi2;
        sccu_pkg::sccu_cfg_t cfg;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [5:0] cnt;
        logic half;
        logic sclk;
        logic sclk_oe;
        logic sdo;
        logic sdo_oe;
        logic fs;
        logic ack;
        logic [31:0] rxw;
    } sccu_eng_t;

    sccu_eng_t q;
    sccu_eng_t d;
    logic active;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d = q;
        d.req1 = lk.req_tgl;
        d.req2 = q.req1;
        d.run1 = lk.run;
        d.run2 = q.run1;
        d.sdi1 = sdi;
        d.sdi2 = q.sdi1;
        d.fs = 1'b0;
        case (q.st)
            E_IDLE:
            begin
                d.half = 1'b0;
                // Word and settings are stable once the toggle has been seen
                if (q.run2 && (q.req2 != q.seen))
                begin
                    d.seen = q.req2;
                    d.cfg = lk.cfg;
                    d.tx = lk.tx_word;
                    d.rx = '0;
                    d.cnt = '0;
                    if (lk.cfg.framed && !lk.cfg.fpe)
                    begin
                        d.st = E_SYNC;
                        d.fs = 1'b1;
                    end
                    else
                    begin
                        d.st = E_SHIFT;
                        d.fs = lk.cfg.framed; // R1
                    end
                end
            end
            E_SYNC:
            begin
                // Pulse fills the bit period ahead of the first bit
                d.half = ~q.half;
                d.fs = ~q.half;
                if (q.half)
                begin
                    d.st = E_SHIFT;
                end
            end
            E_SHIFT:
            begin
                d.half = ~q.half;
                d.fs = q.cfg.framed && q.cfg.fpe && (q.cnt == '0) && !q.half; // R1
                // The sdi flops delay input by one bit time, so the first slot holds no data
                if ((q.half == q.cfg.input_sample_phase) && (q.cnt != '0)) // R10 R13
                begin
                    d.rx = {q.rx[30:0], q.sdi2};
                end
                if (q.half)
                begin
                    d.tx = {q.tx[30:0], 1'b0};
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == (q.cfg.nbits - 6'h01))
                    begin
                        d.st = E_TAIL;
                    end
                end
            end
            E_TAIL:
            begin
                // One idle bit time collects the last input bit
                d.half = ~q.half;
                if (q.half == q.cfg.input_sample_phase) // R10 R13
                begin
                    d.rx = {q.rx[30:0], q.sdi2};
                end
                if (q.half)
                begin
                    d.st = E_DONE;
                end
            end
            E_DONE:
            begin
                d.ack = ~q.ack;
                d.rxw = q.rx;
                d.st = E_IDLE;
            end
            default:
            begin
                d.st = E_IDLE;
            end
        endcase
        // Disable aborts the word but still answers, so the toggles stay paired
        if (!q.run2 && (q.st != E_IDLE) && (q.st != E_DONE)) // R3
        begin
            d.st = E_DONE;
        end
        active = (d.st == E_SHIFT);
        d.sclk = (active && (d.half == d.cfg.cke)) ? ~d.cfg.pol : d.cfg.pol; // R14
        d.sclk_oe = q.run2 && d.cfg.master;
        d.sdo = d.tx[5'(d.cfg.nbits - 6'h01)];
        d.sdo_oe = q.run2 && !d.cfg.pin_rel; // R5
    end

    always_ff @(posedge link_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '{st: E_IDLE, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign lk.ack_tgl = q.ack;
    assign lk.rx_word = q.rxw;
    assign sclk_out = q.sclk;
    assign sclk_oe = q.sclk_oe;
    assign sdo = q.sdo;
    assign sdo_oe = q.sdo_oe;
    assign frame_sync = q.fs;

endmodule : sccu_engine
`default_nettype wire

//--- core/sccu_link_if.sv
// Word handshake between the register side and the link side
`timescale 1ns/1ps
`default_nettype none
interface sccu_link_if;
    logic req_tgl;
    logic [31:0] tx_word;
    sccu_pkg::sccu_cfg_t cfg;
    logic run;
    logic ack_tgl;
    logic [31:0] rx_word;

    modport ctrl (output req_tgl, output tx_word, output cfg, output run,
                  input ack_tgl, input rx_word);
    modport eng (input req_tgl, input tx_word, input cfg, input run,
                 output ack_tgl, output rx_word);
endinterface : sccu_link_if
`default_nettype wire

//--- core/sccu_pkg.sv
// Shared constants and types for the serial port control block
package sccu_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_TX = 8'h08;
    localparam logic [7:0] OFF_RX = 8'h0c;

    ////////////////////////////////////////////////////////////////////////////////
    // Fields of serial_port_control
    localparam int B_FRAMED = 31;
    localparam int B_FPE = 17;
    localparam int B_DEEP = 16;
    localparam int B_ON = 15;
    localparam int B_IDLE_HALT = 13;
    localparam int B_REL = 12;
    localparam int B_WIDE = 11;
    localparam int B_HALF = 10;
    localparam int B_SMP = 9;
    localparam int B_CKE = 8;
    localparam int B_AUDIO = 7;
    localparam int B_POL = 6;
    localparam int B_MASTER = 5;
    localparam logic [31:0] CTRL_MASK = 32'h8003bfe0;
    localparam logic [31:0] CTRL_RST = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // Fields of the status register
    localparam int S_BUSY = 0;
    localparam int S_FULL = 1;
    localparam int S_EMPTY = 2;
    localparam int S_RXV = 3;
    localparam int S_OVF = 4;
    localparam int S_CNT = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Word widths in bits
    localparam logic [5:0] BITS_8 = 6'h08;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_32 = 6'h20;
    localparam logic [5:0] AUDIO_PAD = 6'h08;

    // Settings carried to the link side with every word
    typedef struct packed {
        logic master;
        logic framed;
        logic pol;
        logic cke;
        logic input_sample_phase;
        logic fpe;
        logic pin_rel;
        logic [5:0] nbits;
    } sccu_cfg_t;

endpackage : sccu_pkg

//--- test/sccu_ctrl_sva.sv
// Port-level assertions for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module sccu_ctrl_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_clk,
    input wire logic idle_mode,
    input wire logic sclk_oe,
    input wire logic sdo_oe,
    input wire logic frame_sync
);
    logic on_q, rel_q, idle_halt_q, mst_q, idle_q;
    logic [5:0] quiet_q;
    logic ctl_wr;
    logic settled;
    assign ctl_wr = pready && pwrite && paddr == sccu_pkg::OFF_CTRL;
    // Pin checks wait for the crossing to the link side to settle
    assign settled = quiet_q == 6'h30;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {on_q, rel_q, idle_halt_q, mst_q, idle_q} <= 5'h00;
            quiet_q <= 6'h00;
        end
        else
        begin
            idle_q <= idle_mode;
            if (ctl_wr)
                {on_q, idle_halt_q, rel_q, mst_q} <= {pwdata[15], pwdata[13], pwdata[12], pwdata[5]};
            if (ctl_wr || idle_q != idle_mode)
                quiet_q <= 6'h00;
            else if (!settled)
                quiet_q <= quiet_q + 6'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_ctrl_read;
        s_setup and (!pwrite && paddr == sccu_pkg::OFF_CTRL);
    endsequence
    sequence s_sync_rest;
        frame_sync ##1 !frame_sync;
    endsequence
    AST_ZERO_WAIT: assert property (@(posedge pclk) disable iff (!presetn) s_setup |=> s_access)
        else $error("access phase not answered at once");
    AST_READY_IN_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> psel && penable) else $error("pready outside an access phase");
    AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn) s_setup ##1 s_access
        |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0c)) else $error("pslverr wrong");
    AST_RDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !(pready && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
    AST_SMP_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && !mst_q) ##2 s_ctrl_read |=> !prdata[sccu_pkg::B_SMP])
        else $error("phase bit taken without master enable");
    AST_OFF_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        settled && !on_q |-> !sdo_oe && !sclk_oe) else $error("disabled port drives pins");
    AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
        settled && rel_q |-> !sdo_oe) else $error("released data pin still driven");
    AST_IDLE_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        settled && idle_halt_q && idle_mode |-> !sdo_oe) else $error("port runs in idle");
    AST_RUN_DRIVES: assert property (@(posedge pclk) disable iff (!presetn)
        settled && on_q && !rel_q && !(idle_halt_q && idle_mode) |-> sdo_oe)
        else $error("running port leaves data pin");
    AST_SLAVE_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        settled && !mst_q |-> !sclk_oe) else $error("slave drives the clock");
    AST_SYNC_WIDTH: assert property (@(posedge link_clk) disable iff (!presetn)
        $rose(frame_sync) |=> s_sync_rest) else $error("sync pulse not one bit time");
endmodule : sccu_ctrl_sva
bind sccu_ctrl sccu_ctrl_sva u_sccu_ctrl_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk, .idle_mode, .sclk_oe, .sdo_oe,
    .frame_sync);
`default_nettype wire

//--- test/sccu_partner.sv
// Far-side loopback device on the serial link
`timescale 1ns/1ps
`default_nettype none
module sccu_partner (
    input wire logic link_clk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sdi
);
    logic alt_q = 1'b0;
    always_ff @(posedge link_clk)
        alt_q <= ~alt_q;
    // An undriven data line shows a changing pattern, never a held value
    assign sdi = sdo_oe ? sdo : alt_q;
endmodule : sccu_partner
`default_nettype wire

//--- test/spi_control_config_upper_bench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module spi_control_config_upper_bench;
    localparam int DEPTH = 4;
    logic pclk = 1'b0, link_clk = 1'b0, presetn = 1'b0, idle_mode = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, watch = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_val, d;
    logic pready, pslverr, sdi, sclk_out, sclk_oe, sdo, sdo_oe, frame_sync;
    logic [32:0] exp_q[$];
    int err_count = 0, total_checks = 0, n_sync = 0, n_sclk = 0;
    initial
        forever #2.5 pclk = ~pclk;
    initial
    begin
        #7.3;
        forever #15 link_clk = ~link_clk;
    end
    sccu_ctrl #(.DEEP_DEPTH(DEPTH)) u_sccu_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk, .sdi, .idle_mode, .sclk_out,
        .sclk_oe, .sdo, .sdo_oe, .frame_sync);
    sccu_partner u_sccu_partner (.link_clk, .sdo, .sdo_oe, .sdi);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic chk, input logic [32:0] exp);
        if (chk)
            exp_q.push_back(exp);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        watch <= chk;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd_val = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle so no signal is driven twice in a time step
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 1'b1, 33'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, 1'b1, e);
    endtask : rd
    task automatic wait_stat(input int bitn, input logic v);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, sccu_pkg::OFF_STAT, 32'h0, 1'b0, 33'h0);
            n++;
        end
        while (rd_val[bitn] !== v && n < 1000);
        check("status poll", {32'h0, v}, {32'h0, rd_val[bitn]});
    endtask : wait_stat
    function automatic logic [31:0] wmask(input logic au, input logic w, input logic h);
        if (au)
            return w ? (h ? 32'h00ffffff : 32'hffffffff) : 32'h0000ffff;
        return w ? 32'hffffffff : (h ? 32'h0000ffff : 32'h000000ff);
    endfunction : wmask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
        if (pready === 1'b1 && watch === 1'b1)
            check("apb answer", exp_q.pop_front(), {pslverr, prdata});
    always @(posedge frame_sync)
        n_sync++;
    always @(posedge sclk_out)
        n_sclk++;
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(30671));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(sccu_pkg::OFF_CTRL, {1'b0, sccu_pkg::CTRL_RST});
        rd(sccu_pkg::OFF_STAT, 33'h4);
        apb(1'b1, 8'h10, 32'hffffffff, 1'b1, 33'h100000000);
        rd(8'h14, 33'h100000000);
        $display("test reset and map done");
        wr(sccu_pkg::OFF_CTRL, 32'h00000220);
        rd(sccu_pkg::OFF_CTRL, 33'h020);
        wr(sccu_pkg::OFF_CTRL, 32'h00000220);
        rd(sccu_pkg::OFF_CTRL, 33'h220);
        wr(sccu_pkg::OFF_CTRL, 32'hfffffeff);
        rd(sccu_pkg::OFF_CTRL, {1'b0, sccu_pkg::CTRL_MASK & 32'hfffffeff});
        wr(sccu_pkg::OFF_CTRL, 32'h00008020);
        rd(sccu_pkg::OFF_CTRL, 33'h18020);
        $display("test control access done");
        for (int m = 0; m < 16; m++)
        begin
            d = $urandom();
            wr(sccu_pkg::OFF_CTRL, 32'h8020 | {m[2:1], 10'h0} | (m[0] ? 32'h80 : 32'h0)
                | (m[3] ? 32'h200 : 32'h0));
            n_sclk = 0;
            wr(sccu_pkg::OFF_TX, d);
            wait_stat(sccu_pkg::S_RXV, 1'b1);
            wait_stat(sccu_pkg::S_BUSY, 1'b0);
            if (m == 0)
                check("clock edges", 33'h8, 33'(n_sclk));
            rd(sccu_pkg::OFF_STAT, 33'h0c);
            rd(sccu_pkg::OFF_RX, {1'b0, d & wmask(m[0], m[2], m[1])});
            rd(sccu_pkg::OFF_STAT, 33'h04);
        end
        $display("test word widths done");
        for (int k = 0; k < 2; k++)
        begin
            wr(sccu_pkg::OFF_CTRL, 32'h0);
            wr(sccu_pkg::OFF_CTRL, k ? 32'h10020 : 32'h00020);
            idle_mode <= 1'b1;
            wr(sccu_pkg::OFF_CTRL, (k ? 32'h10000 : 32'h0) | 32'ha020);
            for (int i = 0; i <= (k ? DEPTH : 1); i++)
                wr(sccu_pkg::OFF_TX, $urandom());
            rd(sccu_pkg::OFF_STAT, {1'b0, 32'h12 | 32'((k ? DEPTH : 1) << 8)});
            wr(sccu_pkg::OFF_STAT, 32'h10);
            idle_mode <= 1'b0;
            wait_stat(sccu_pkg::S_EMPTY, 1'b1);
            wait_stat(sccu_pkg::S_BUSY, 1'b0);
            rd(sccu_pkg::OFF_STAT, 33'h0c);
            apb(1'b0, sccu_pkg::OFF_RX, 32'h0, 1'b0, 33'h0);
        end
        $display("test buffering done");
        wr(sccu_pkg::OFF_CTRL, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            wr(sccu_pkg::OFF_CTRL, 32'h80008020 | (k ? 32'h21000 : 32'h0));
            wr(sccu_pkg::OFF_TX, $urandom());
            wait_stat(sccu_pkg::S_RXV, 1'b1);
            wait_stat(sccu_pkg::S_BUSY, 1'b0);
            apb(1'b0, sccu_pkg::OFF_RX, 32'h0, 1'b0, 33'h0);
        end
        check("sync pulses", 33'h2, 33'(n_sync));
        $display("test framed done");
        wrap_up();
    end
endmodule : spi_control_config_upper_bench
`default_nettype wire
